// >>> rtl/tcw_pkg.sv
// package for the 8-bit timer compare and waveform unit
// assumes a single pclk domain and an apb slave with 32-bit data
package tcw_pkg;
    // -------------------------------------------------------------
    // widths
    // -------------------------------------------------------------
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int CNT_W  = 8;
    localparam int DIV_W  = 8;
    // -------------------------------------------------------------
    // register byte offsets
    // -------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_COUNT  = 8'h04;
    localparam logic [7:0] OFF_CMPA   = 8'h08;
    localparam logic [7:0] OFF_CMPB   = 8'h0c;
    localparam logic [7:0] OFF_FLAGS  = 8'h10;
    localparam logic [7:0] OFF_FORCE  = 8'h14;
    localparam logic [7:0] OFF_PINCTL = 8'h18;
    localparam logic [7:0] OFF_CLKDIV = 8'h1c;
    localparam logic [7:0] OFF_STATUS = 8'h20;
    // -------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------
    localparam int MODE_LSB  = 0;
    localparam int COMB_LSB  = 4;
    localparam int COMA_LSB  = 6;
    localparam int TOV_BIT   = 0;
    localparam int OCFA_BIT  = 1;
    localparam int OCFB_BIT  = 2;
    localparam int CH_A      = 0;
    localparam int CH_B      = 1;
    localparam int DIR_LSB   = 2;
    // -------------------------------------------------------------
    // codes and reset values
    // -------------------------------------------------------------
    localparam logic [2:0] MODE_NORMAL   = 3'h0;
    localparam logic [2:0] MODE_CTC      = 3'h2;
    localparam logic [2:0] MODE_FAST_MAX = 3'h3;
    localparam logic [2:0] MODE_FAST_A   = 3'h7;
    localparam int         MODE_UP_BIT   = 2;
    localparam logic [1:0] COM_OFF    = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR  = 2'h2;
    localparam logic [1:0] COM_SET    = 2'h3;
    localparam logic [CNT_W-1:0] CNT_MAX    = 8'hff;
    localparam logic [CNT_W-1:0] CNT_BOTTOM = 8'h00;
    localparam logic [DIV_W-1:0] DIV_RESET  = 8'h01;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        TCW_FREE  = 2'b00,
        TCW_CLEAR = 2'b01,
        TCW_FAST  = 2'b10
    } tcw_cnt_e;
endpackage : tcw_pkg

// >>> rtl/tcw_chan_if.sv
// carrier between the counter core and one compare output channel
// assumes all members are sampled on pclk
`timescale 1ns/1ps
interface tcw_chan_if;
    logic       match;
    logic       wrap;
    logic       force_cmp;
    logic       nonpwm;
    logic       fast;
    logic       upper;
    logic [1:0] com;
    logic       wave;
    modport ctl  (output match, wrap, force_cmp, nonpwm, fast, upper, com, input wave);
    modport chan (input match, wrap, force_cmp, nonpwm, fast, upper, com, output wave);
endinterface : tcw_chan_if

// >>> rtl/tcw_tick_div.sv
// timer clock enable divider: one-cycle tick every div_val pclk cycles
// assumes div_val is static between ticks; zero stops the timer
`timescale 1ns/1ps
module tcw_tick_div #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // control
    input  wire logic [W-1:0] div_val,
    // enable out
    output logic              tick
);
    import tcw_pkg::*;
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         tick;
    } tcw_div_s;
    tcw_div_s s, n;
    logic     last;

    always_comb begin
        n = s;
        last = (s.cnt >= div_val - W'(1));
        n.tick = (div_val != '0) && last;
        if ((div_val == '0) || last) begin
            n.cnt = '0;
        end else begin
            n.cnt = s.cnt + W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign tick = s.tick;
endmodule : tcw_tick_div

// >>> rtl/tcw_chan.sv
// one compare output channel: holds the internal waveform bit
// assumes match/wrap are already qualified by the timer tick
`timescale 1ns/1ps
module tcw_chan #(
    parameter bit IS_A = 1'b0
) (
    // clock and reset
    input  wire logic   pclk,
    input  wire logic   presetn,
    // core side
    tcw_chan_if.chan    c
);
    import tcw_pkg::*;
    typedef struct packed {
        logic wave;
    } tcw_chan_s;
    tcw_chan_s s, n;

    always_comb begin
        n = s;
        if (c.nonpwm && (c.match || c.force_cmp)) begin               // [R6]
            unique case (c.com)
                COM_OFF:    n.wave = s.wave;                          // [R4]
                COM_TOGGLE: n.wave = ~s.wave;                         // [R13]
                COM_CLEAR:  n.wave = 1'b0;
                COM_SET:    n.wave = 1'b1;
            endcase
        end else if (c.fast) begin
            unique case (c.com)
                COM_OFF:    n.wave = s.wave;                          // [R4]
                // toggle is channel A only and needs the upper mode bit
                COM_TOGGLE: n.wave = (IS_A && c.upper && c.match) ? ~s.wave : s.wave; // [R19]
                // bottom action wins so a compare at top gives a steady level
                COM_CLEAR:  n.wave = c.wrap ? 1'b1 : (c.match ? 1'b0 : s.wave); // [R18]
                COM_SET:    n.wave = c.wrap ? 1'b0 : (c.match ? 1'b1 : s.wave); // [R18]
            endcase
        end
    end

    // no mode change touches the bit, only reset and compare actions change it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;                                                  // [R2]
        end else begin
            s <= n;                                                   // [R7]
        end
    end

    assign c.wave = s.wave;
endmodule : tcw_chan

// >>> rtl/tcw_core.sv
// 8-bit timer counter with two compare output channels, apb slave
// assumes apb master per amba; one clock pclk, async active-low reset
//
// Operation
// R1: counter write blocks matches next timer tick
// R2: reset clears internal waveform bits
// R3: nonzero output mode overrides port; direction separate
// R4: output mode zero leaves waveform bit alone
// R5: output mode acts immediately, not buffered
// R6: force strobe applies action in non-pwm modes
// R7: waveform bits kept across mode changes
// R8: mode field picks counting; output mode only actions
// R9: normal mode counts up, wraps ff to 00
// R10: normal overflow flag set as counter hits zero
// R11: clear-on-match mode clears at compare A
// R12: compare A below count: run to ff, wrap
// R13: clear-on-match toggle mode toggles output A
// R14: clear-on-match overflow flag on ff to 00
// R15: fast pwm modes 3 and 7, top ff/A
// R16: fast pwm clears counter tick after top
// R17: fast pwm overflow flag set at top
// R18: fast pwm modes 2/3 non-inverted and inverted
// R19: fast pwm toggle only channel A, upper bit
// R20: software avoids writing counter equal to compare
// R21: software sets waveform before enabling pin
// R22: match sets compare flag; write one clears
// R23: compare buffered in pwm, direct otherwise
// R24: forced compare sets no flag, keeps counter
// R25: all updates on pclk qualified by tick
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module tcw_core (
    // clock and reset
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    // apb slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [tcw_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [tcw_pkg::DATA_W-1:0]  pwdata,
    output logic      [tcw_pkg::DATA_W-1:0]  prdata,
    output logic                             pready,
    output logic                             pslverr,
    // waveform pins, oe low while driving
    output logic                             pin_a_out,
    output logic                             pin_a_oe_n,
    output logic                             pin_b_out,
    output logic                             pin_b_oe_n
);
    import tcw_pkg::*;

    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    typedef struct packed {
        logic [2:0]        mode;
        logic [1:0]        com_a;
        logic [1:0]        com_b;
        logic [CNT_W-1:0]  cnt;
        logic [CNT_W-1:0]  ocra_buf;
        logic [CNT_W-1:0]  ocrb_buf;
        logic [CNT_W-1:0]  ocra;
        logic [CNT_W-1:0]  ocrb;
        logic              tov;
        logic              ocfa;
        logic              ocfb;
        logic              block;
        logic [1:0]        port_val;
        logic [1:0]        dir;
        logic [DIV_W-1:0]  div;
        logic              force_a;
        logic              force_b;
        logic [DATA_W-1:0] prdata;
        logic              pready;
        logic              pslverr;
        logic              pin_a;
        logic              pin_b;
        logic              oe_a_n;
        logic              oe_b_n;
    } tcw_core_s;

    tcw_core_s         s, n;
    tcw_cnt_e          cmode;
    logic              tick;
    logic              wr;
    logic              setup;
    logic              cnt_wr;
    logic              fast;
    logic              nonpwm;
    logic [CNT_W-1:0]  top;
    logic              m_a;
    logic              m_b;
    logic              wrap_top;
    logic              tov_set;
    logic              hit;
    logic [DATA_W-1:0] rdata;
    logic              wave_a;
    logic              wave_b;

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    function automatic tcw_cnt_e cnt_mode(input logic [2:0] m);
        unique case (m)
            MODE_CTC:      cnt_mode = TCW_CLEAR;                      // [R8]
            MODE_FAST_MAX: cnt_mode = TCW_FAST;
            MODE_FAST_A:   cnt_mode = TCW_FAST;
            // phase-correct and reserved codes count freely here
            default:       cnt_mode = TCW_FREE;
        endcase
    endfunction : cnt_mode

    function automatic logic cmp_hit(input logic [CNT_W-1:0] c,
                                     input logic [CNT_W-1:0] o,
                                     input logic             blk);
        cmp_hit = (c == o) && !blk;                                   // [R1]
    endfunction : cmp_hit

    function automatic logic w1c(input logic f, input logic clr, input logic set);
        // a set in the clearing cycle survives
        w1c = (f && !clr) || set;
    endfunction : w1c

    // -------------------------------------------------------------
    // timer enable and channels
    // -------------------------------------------------------------
    tcw_tick_div #(.W(DIV_W)) u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .div_val (s.div),
        .tick    (tick)
    );

    tcw_chan_if ch_a_if ();
    tcw_chan_if ch_b_if ();

    assign ch_a_if.match     = m_a;
    assign ch_a_if.wrap      = wrap_top;
    assign ch_a_if.force_cmp = s.force_a;
    assign ch_a_if.nonpwm    = nonpwm;
    assign ch_a_if.fast      = fast;
    assign ch_a_if.upper     = s.mode[MODE_UP_BIT];
    assign ch_a_if.com       = s.com_a;                               // [R5]
    assign ch_b_if.match     = m_b;
    assign ch_b_if.wrap      = wrap_top;
    assign ch_b_if.force_cmp = s.force_b;
    assign ch_b_if.nonpwm    = nonpwm;
    assign ch_b_if.fast      = fast;
    assign ch_b_if.upper     = s.mode[MODE_UP_BIT];
    assign ch_b_if.com       = s.com_b;
    assign wave_a            = ch_a_if.wave;
    assign wave_b            = ch_b_if.wave;

    tcw_chan #(.IS_A(1'b1)) u_chan_a (
        .pclk    (pclk),
        .presetn (presetn),
        .c       (ch_a_if.chan)
    );

    tcw_chan #(.IS_A(1'b0)) u_chan_b (
        .pclk    (pclk),
        .presetn (presetn),
        .c       (ch_b_if.chan)
    );

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------
    always_comb begin
        n        = s;
        cmode    = cnt_mode(s.mode);
        setup    = psel && !penable;
        wr       = psel && penable && pwrite && s.pready;
        cnt_wr   = wr && (paddr == OFF_COUNT);
        fast     = (cmode == TCW_FAST);
        nonpwm   = (s.mode == MODE_NORMAL) || (s.mode == MODE_CTC);
        top      = ((s.mode == MODE_FAST_A) || (s.mode == MODE_CTC)) ? s.ocra : CNT_MAX; // [R15]
        // a counter write overrides whatever the tick would do
        m_a      = tick && !cnt_wr && cmp_hit(s.cnt, s.ocra, s.block);  // [R25]
        m_b      = tick && !cnt_wr && cmp_hit(s.cnt, s.ocrb, s.block);
        wrap_top = tick && !cnt_wr && fast && (s.cnt == top);
        tov_set  = tick && !cnt_wr && (fast ? (s.cnt == top)           // [R17]
                                            : (s.cnt == CNT_MAX));    // [R10] [R14]
        n.force_a = 1'b0;
        n.force_b = 1'b0;

        // counter
        if (cnt_wr) begin
            n.cnt = pwdata[CNT_W-1:0];
        end else if (tick) begin
            unique case (cmode)
                TCW_FREE:  n.cnt = s.cnt + CNT_W'(1);                 // [R9]
                TCW_CLEAR: n.cnt = (s.cnt == s.ocra) ? CNT_BOTTOM     // [R11]
                                                     : s.cnt + CNT_W'(1); // [R12]
                TCW_FAST:  n.cnt = (s.cnt == top) ? CNT_BOTTOM        // [R16]
                                                  : s.cnt + CNT_W'(1);
            endcase
        end
        // block lasts until the next tick, even with the timer stopped
        if (cnt_wr) begin
            n.block = 1'b1;                                           // [R1]
        end else if (tick) begin
            n.block = 1'b0;
        end

        // register writes
        if (wr) begin
            unique case (paddr)
                OFF_CTRL: begin
                    n.mode  = pwdata[MODE_LSB +: 3];
                    n.com_b = pwdata[COMB_LSB +: 2];
                    n.com_a = pwdata[COMA_LSB +: 2];
                end
                OFF_CMPA:   n.ocra_buf = pwdata[CNT_W-1:0];
                OFF_CMPB:   n.ocrb_buf = pwdata[CNT_W-1:0];
                OFF_FORCE: begin
                    n.force_a = pwdata[CH_A];                         // [R6]
                    n.force_b = pwdata[CH_B];
                end
                OFF_PINCTL: begin
                    n.port_val = pwdata[CH_A +: 2];
                    n.dir      = pwdata[DIR_LSB +: 2];
                end
                OFF_CLKDIV: n.div = pwdata[DIV_W-1:0];
                default: ;
            endcase
        end
        // compare registers: direct outside pwm, loaded at top in pwm
        if (!fast) begin
            n.ocra = n.ocra_buf;                                      // [R23]
            n.ocrb = n.ocrb_buf;
        end else if (wrap_top) begin
            n.ocra = s.ocra_buf;                                      // [R23]
            n.ocrb = s.ocrb_buf;
        end

        // flags: a forced compare never reaches these
        n.tov  = w1c(s.tov,  wr && (paddr == OFF_FLAGS) && pwdata[TOV_BIT],  tov_set);
        n.ocfa = w1c(s.ocfa, wr && (paddr == OFF_FLAGS) && pwdata[OCFA_BIT], m_a); // [R22] [R24]
        n.ocfb = w1c(s.ocfb, wr && (paddr == OFF_FLAGS) && pwdata[OCFB_BIT], m_b);

        // read mux, sampled in the setup cycle
        hit   = 1'b1;
        rdata = DATA_ZERO;
        unique case (paddr)
            OFF_CTRL: begin
                rdata[MODE_LSB +: 3] = s.mode;
                rdata[COMB_LSB +: 2] = s.com_b;
                rdata[COMA_LSB +: 2] = s.com_a;
            end
            OFF_COUNT:  rdata[CNT_W-1:0] = s.cnt;
            OFF_CMPA:   rdata[CNT_W-1:0] = s.ocra_buf;
            OFF_CMPB:   rdata[CNT_W-1:0] = s.ocrb_buf;
            OFF_FLAGS: begin
                rdata[TOV_BIT]  = s.tov;
                rdata[OCFA_BIT] = s.ocfa;
                rdata[OCFB_BIT] = s.ocfb;
            end
            OFF_FORCE:  rdata = DATA_ZERO;
            OFF_PINCTL: begin
                rdata[CH_A +: 2]    = s.port_val;
                rdata[DIR_LSB +: 2] = s.dir;
            end
            OFF_CLKDIV: rdata[DIV_W-1:0] = s.div;
            OFF_STATUS: begin
                rdata[CH_A] = wave_a;
                rdata[CH_B] = wave_b;
            end
            default:    hit = 1'b0;
        endcase
        // zero-wait slave: ready is raised for the single access cycle
        n.pready  = setup;
        n.pslverr = setup && !hit;
        if (setup) begin
            n.prdata = pwrite ? DATA_ZERO : rdata;
        end

        // pins: registered so every output leaves a flip-flop
        n.pin_a  = (s.com_a != COM_OFF) ? wave_a : s.port_val[CH_A];  // [R3]
        n.pin_b  = (s.com_b != COM_OFF) ? wave_b : s.port_val[CH_B];
        n.oe_a_n = !s.dir[CH_A];                                      // [R3]
        n.oe_b_n = !s.dir[CH_B];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s     <= '0;
            s.div <= DIV_RESET;
            s.oe_a_n <= 1'b1;
            s.oe_b_n <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign prdata     = s.prdata;
    assign pready     = s.pready;
    assign pslverr    = s.pslverr;
    assign pin_a_out  = s.pin_a;
    assign pin_a_oe_n = s.oe_a_n;
    assign pin_b_out  = s.pin_b;
    assign pin_b_oe_n = s.oe_b_n;

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_block_no_flag: assert property (s.block && tick && !cnt_wr && !s.ocfa |=> !s.ocfa) // [R1]
        else $error("match not blocked after counter write");
    a_normal_wrap: assert property (tick && !cnt_wr && s.mode == MODE_NORMAL // [R9] [R10]
        && s.cnt == CNT_MAX |=> s.cnt == CNT_BOTTOM && s.tov)
        else $error("normal mode wrap or overflow wrong");
    a_ctc_clear: assert property (tick && !cnt_wr && s.mode == MODE_CTC // [R11]
        && s.cnt == s.ocra |=> s.cnt == CNT_BOTTOM)
        else $error("clear-on-match did not clear");
    a_ctc_miss: assert property (tick && !cnt_wr && s.mode == MODE_CTC // [R12]
        && s.cnt > s.ocra && s.cnt != CNT_MAX |=> s.cnt == $past(s.cnt) + CNT_W'(1))
        else $error("counter did not run past compare");
    a_fast_top: assert property (tick && !cnt_wr && s.mode == MODE_FAST_MAX // [R16] [R17]
        && s.cnt == CNT_MAX |=> s.cnt == CNT_BOTTOM && s.tov)
        else $error("fast pwm top handling wrong");
    a_flag_set: assert property (m_a |=> s.ocfa) // [R22]
        else $error("compare flag a not set");
    a_flag_clear: assert property (wr && paddr == OFF_FLAGS && pwdata[OCFA_BIT] // [R22]
        && !m_a |=> !s.ocfa)
        else $error("compare flag a not cleared");
    a_force_keeps: assert property (s.force_a && !tick && !cnt_wr && !s.ocfa // [R24]
        |=> !s.ocfa && s.cnt == $past(s.cnt))
        else $error("forced compare touched flag or counter");
    a_pin_override: assert property (s.com_a != COM_OFF |=> s.pin_a == $past(wave_a)) // [R3]
        else $error("pin a not driven by waveform");
    a_pin_dir: assert property (##1 s.oe_b_n == !$past(s.dir[CH_B])) // [R3]
        else $error("pin b enable not following direction");

    c_fast_wrap: cover property (wrap_top ##1 s.cnt == CNT_BOTTOM);
    c_ctc_toggle: cover property (m_a && s.mode == MODE_CTC && s.com_a == COM_TOGGLE);
    c_force: cover property (s.force_a && nonpwm && s.com_a != COM_OFF);
endmodule : tcw_core

// >>> test/timer8_compare_waveform_unit_tb_top.sv
// self-checking bench for tcw_core: apb register sequences with expected values
// assumes the zero-wait apb slave and register map of tcw_pkg; drives all ports itself
`timescale 1ns/1ps
module timer8_compare_waveform_unit_tb_top;
    import tcw_pkg::*;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic               pclk    = 1'b0;
    logic               presetn = 1'b0;
    logic               psel    = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite  = 1'b0;
    logic [ADDR_W-1:0]  paddr   = 8'h00;
    logic [DATA_W-1:0]  pwdata  = 32'h0;
    logic [DATA_W-1:0]  prdata;
    logic               pready, pslverr, pin_a_out, pin_a_oe_n, pin_b_out, pin_b_oe_n;
    logic [DATA_W-1:0]  rdat, cnt, flg, st;
    logic               se;
    logic [1:0]         scen_com_b = 2'h0;
    int                 errors = 0;
    int                 num_checks = 0;

    always #50 pclk = ~pclk;

    tcw_core u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .pin_a_out, .pin_a_oe_n, .pin_b_out, .pin_b_oe_n);
    // ----------------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------------
    // one edge passes before each setup so a release is never overwritten in one step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        // a ready on the last allowed edge is an answer, not a hang
        if (pready !== 1'b1) begin
            errors++;
            $display("[FAIL] %0t apb hang", $time);
        end
        rdat = prdata;
        se   = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask : wr
    task automatic rd(input logic [7:0] a); apb(1'b0, a, 32'h0); endtask : rd
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin errors++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end
    endtask : chk
    // stopped timer is loaded, then run for about twenty ticks and stopped again
    task automatic scen(input logic [2:0] m, input logic [1:0] ca, input logic [7:0] c0, cp);
        wr(OFF_CTRL, 32'h0);
        wr(OFF_CMPA, {24'h0, cp});
        wr(OFF_COUNT, {24'h0, c0});
        wr(OFF_FLAGS, 32'h7);
        wr(OFF_CTRL, {24'h0, ca, scen_com_b, 1'b0, m});
        wr(OFF_CLKDIV, 32'h1);
        repeat (20) @(posedge pclk);
        wr(OFF_CLKDIV, 32'h0);
        rd(OFF_COUNT); cnt = rdat;
        rd(OFF_FLAGS); flg = rdat;
        rd(OFF_STATUS); st = rdat;
    endtask : scen
    task automatic frc(input logic [1:0] ca, input logic [2:0] m, input logic [31:0] e);
        wr(OFF_CTRL, {24'h0, ca, 3'h0, m});
        wr(OFF_FORCE, 32'h1);
        rd(OFF_STATUS);
        chk(rdat, e);
    endtask : frc
    task automatic summarize;
        if (errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize
    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        #(100 * 10000);
        errors++;
        summarize();
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        chk({31'h0, pin_a_oe_n}, 32'h1);
        rd(OFF_CLKDIV); chk(rdat, 32'h1);
        rd(OFF_STATUS); chk(rdat, 32'h0);
        rd(8'h40); chk({rdat[30:0], se}, 32'h1);
        wr(OFF_CLKDIV, 32'h0);
        // the timer ran from reset and matched at zero: start the force checks clean
        wr(OFF_FLAGS, 32'h7);
        wr(OFF_COUNT, 32'h0);
        frc(COM_SET, MODE_NORMAL, 32'h1);
        rd(OFF_FLAGS); chk(rdat, 32'h0);
        rd(OFF_COUNT); chk(rdat, 32'h0);
        frc(COM_OFF, MODE_NORMAL, 32'h1);
        frc(COM_TOGGLE, MODE_NORMAL, 32'h0);
        frc(COM_SET, MODE_CTC, 32'h1);
        frc(COM_CLEAR, MODE_FAST_MAX, 32'h1);
        wr(OFF_PINCTL, 32'h4);
        repeat (2) @(posedge pclk);
        chk({30'h0, pin_a_out, pin_a_oe_n}, 32'h2);
        wr(OFF_CTRL, 32'h0);
        repeat (2) @(posedge pclk);
        chk({30'h0, pin_a_out, pin_a_oe_n}, 32'h0);
        scen(MODE_CTC, COM_TOGGLE, 8'h00, 8'h10); chk(st, 32'h0);
        scen(MODE_FAST_MAX, COM_CLEAR, 8'hf0, 8'h80); chk(st, 32'h1);
        chk({flg[0], cnt[7:0] < 8'h80}, 2'h3);
        scen(MODE_FAST_MAX, COM_SET, 8'hf0, 8'h80); chk(st, 32'h0);
        scen(MODE_FAST_MAX, COM_TOGGLE, 8'h70, 8'h80); chk(st, 32'h0);
        scen(MODE_FAST_A, COM_TOGGLE, 8'h00, 8'h10); chk(st, 32'h1);
        chk({flg[0], cnt[7:0] < 8'h10}, 2'h3);
        scen(MODE_CTC, COM_OFF, 8'h00, 8'h03); chk(st, 32'h1);
        chk({flg[1:0], cnt[7:0] <= 8'h03}, 3'h5);
        scen(MODE_CTC, COM_OFF, 8'h80, 8'h03); chk({flg[0], cnt[7:0] >= 8'h90}, 2'h1);
        scen(MODE_CTC, COM_OFF, 8'hf0, 8'hff); chk(flg[0], 1'b1);
        scen(MODE_NORMAL, COM_OFF, 8'hf0, 8'h03); chk({flg[1:0], cnt[7:0] > 8'h03}, 3'h7);
        scen(MODE_FAST_MAX, COM_OFF, 8'h00, 8'h03); chk({flg[0], cnt[7:0] > 8'h03}, 2'h1);
        scen(MODE_NORMAL, COM_OFF, 8'h20, 8'h20); chk(flg[1], 1'b0);
        scen(MODE_NORMAL, COM_OFF, 8'h1f, 8'h20); chk(flg[1], 1'b1);
        wr(OFF_FLAGS, 32'h2);
        rd(OFF_FLAGS); chk(rdat[1], 1'b0);
        // channel b: port value, then forced set, then no fast pwm toggle
        wr(OFF_PINCTL, 32'h8);
        repeat (2) @(posedge pclk);
        chk({30'h0, pin_b_out, pin_b_oe_n}, 32'h0);
        wr(OFF_CTRL, {24'h0, COM_OFF, COM_SET, 1'b0, MODE_NORMAL});
        wr(OFF_FORCE, 32'h2);
        rd(OFF_STATUS); chk(rdat, 32'h3);
        chk({30'h0, pin_b_out, pin_b_oe_n}, 32'h2);
        scen_com_b = COM_TOGGLE;
        scen(MODE_FAST_A, COM_OFF, 8'h00, 8'h10); chk(st, 32'h3);
        chk(flg[2], 1'b1);
        summarize();
    end
endmodule : timer8_compare_waveform_unit_tb_top
